/* core/iia_defs.svh */
/*
 Timing-free constants for the indirect indexed address generator:
 field widths and reset values.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef IIA_DEFS_SVH
`define IIA_DEFS_SVH
`define IIA_ADDR_W 16
`define IIA_SHORT_SUM_W 9
`define IIA_ADDR_RST 16'h0000
`define IIA_BYTE_RST 8'h00
`endif

/* core/iia_pkg.sv */
/*
 Types for the indirect indexed address generator.
 Assumes iia_defs.svh is on the include path.
*/
`include "iia_defs.svh"
package iia_pkg;
    typedef enum logic [3:0] {
        load_op, compare_op, and_op, or_op, xor_op, add_op, add_with_carry_op,
        subtract_op, subtract_with_borrow_op, bit_compare_op, other_op
    } op_t;

    typedef struct packed {
        logic long_form;
        logic use_second_index;
        op_t op;
        logic [7:0] ptr_loc;
    } request_t;

    typedef struct packed {
        logic [15:0] addr;
        op_t op;
    } result_t;
endpackage

/* core/indirect_indexed_address_gen.sv */
/*
 Operand address generator for indirect indexed addressing, short and long.
 Assumes a memory with one-cycle read latency (data valid the cycle after
 mem_rd), and index registers held stable during a request.
*/
// What this block does
// - Operand address is fetched pointer plus chosen index, unsigned.
// - Pointer location comes from the single byte after the opcode.
// - Short form fetches one byte; address spans 000 to 1FE.
// - Long form fetches a two-byte pointer reaching all 64 Kbytes.
// - Load, compare, logic, add, subtract and bit-compare use both forms.
`include "iia_defs.svh"
module indirect_indexed_address_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Request from decode
    input wire logic req_valid,
    output logic req_ready,
    input iia_pkg::request_t req,
    // Index registers
    input wire logic [7:0] index_first,
    input wire logic [7:0] index_second,
    // Memory port
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Result
    output logic res_valid,
    output iia_pkg::result_t res,
    output logic res_illegal
);
    typedef enum logic [2:0] {IDLE, HI, LO, WAIT_LO, DONE} state_t;
    state_t state_q, state_d;
    iia_pkg::request_t req_q, req_d;
    logic [7:0] hi_q, hi_d;
    iia_pkg::result_t res_q, res_d;
    logic illegal_q, illegal_d;
    logic supported;
    logic [7:0] idx;
    logic [8:0] short_sum;
    logic [15:0] long_sum;

    always_comb
    begin
        supported = (req.op != iia_pkg::other_op);
        idx = req_q.use_second_index ? index_second : index_first;
        // Short pointer plus index never exceeds 1FE, so no carry is lost
        short_sum = {1'b0, mem_rdata} + {1'b0, idx};
        long_sum = {hi_q, mem_rdata} + {8'h00, idx};
        state_d = state_q;
        req_d = req_q;
        hi_d = hi_q;
        res_d = res_q;
        illegal_d = illegal_q;
        mem_rd = 1'b0;
        mem_addr = `IIA_ADDR_RST;
        case (state_q)
            IDLE:
            begin
                if (req_valid)
                begin
                    req_d = req;
                    if (!supported)
                    begin
                        illegal_d = 1'b1;
                        res_d.op = req.op;
                        res_d.addr = `IIA_ADDR_RST;
                        state_d = DONE;
                    end
                    else
                    begin
                        illegal_d = 1'b0;
                        mem_rd = 1'b1;
                        // Pointer location is the single byte after opcode
                        mem_addr = {8'h00, req.ptr_loc};
                        state_d = req.long_form ? HI : WAIT_LO;
                    end
                end
            end
            HI:
            begin
                hi_d = mem_rdata;
                mem_rd = 1'b1;
                // Low byte of a word pointer sits one byte higher
                mem_addr = {8'h00, req_q.ptr_loc} + 16'h0001;
                state_d = LO;
            end
            LO, WAIT_LO:
            begin
                res_d.op = req_q.op;
                if (state_q == LO)
                    res_d.addr = long_sum;
                else
                    res_d.addr = {7'h00, short_sum};
                state_d = DONE;
            end
            DONE: state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= IDLE;
            req_q <= '0;
            hi_q <= `IIA_BYTE_RST;
            res_q <= '0;
            illegal_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_q <= req_d;
            hi_q <= hi_d;
            res_q <= res_d;
            illegal_q <= illegal_d;
        end
    end

    assign req_ready = (state_q == IDLE);
    assign res_valid = (state_q == DONE);
    assign res = res_q;
    assign res_illegal = illegal_q;

    // Sums are rebuilt from memory data, index pins, hi_q, req_q and idx, not from short_sum or long_sum
    property p_ptr_loc;
        @(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && req.op != iia_pkg::other_op)
            |-> mem_rd && mem_addr == {8'h00, req.ptr_loc};
    endproperty
    a_ptr_loc: assert property (p_ptr_loc)
        else $error("bad pointer loc");

    property p_low_loc;
        @(posedge sys_clk) disable iff (reset)
        (state_q == HI)
            |-> mem_rd && mem_addr == $past(mem_addr) + 16'h0001;
    endproperty
    a_low_loc: assert property (p_low_loc) else $error("low loc");

    property p_short;
        @(posedge sys_clk) disable iff (reset)
        (state_q == WAIT_LO) |=> res_valid && res.addr <= 16'h01FE
            && res.addr == {8'h00, $past(mem_rdata)}
            + ($past(req_q.use_second_index)
            ? $past(index_second) : $past(index_first));
    endproperty
    a_short: assert property (p_short) else $error("bad short address");

    property p_long_timing;
        @(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && req.long_form
            && req.op != iia_pkg::other_op) |=> mem_rd ##1 !mem_rd ##1 res_valid;
    endproperty
    a_long_timing: assert property (p_long_timing)
        else $error("long seq");

    property p_long_sum;
        @(posedge sys_clk) disable iff (reset)
        (state_q == LO) |=> res.addr == $past(hi_q) * 16'h0100
            + $past(mem_rdata) + ($past(req_q.use_second_index)
            ? $past(index_second) : $past(index_first));
    endproperty
    a_long_sum: assert property (p_long_sum) else $error("long sum");

    property p_short_one_fetch;
        @(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && !req.long_form
            && req.op != iia_pkg::other_op) |=> !mem_rd ##1 res_valid;
    endproperty
    a_short_one_fetch: assert property (p_short_one_fetch)
        else $error("short");

    property p_supported;
        @(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready) |-> ##[1:3] (res_valid
            && res_illegal == (res.op == iia_pkg::other_op));
    endproperty
    a_supported: assert property (p_supported)
        else $error("op support");

    property p_illegal;
        @(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && req.op == iia_pkg::other_op)
            |-> !mem_rd
            ##1 (res_valid && res_illegal && res.addr == 16'h0000);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal op");

    // A word pointer near FFFF plus the index drops its carry, never spills
    property p_wrap;
        @(posedge sys_clk) disable iff (reset)
        (state_q == LO
            && (17'({hi_q, mem_rdata}) + 17'(idx)) > 17'h0FFFF)
            |=> res.addr < 16'h0100;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_reset_idle;
        @(posedge sys_clk)
        reset |=> req_ready && !res_valid && !res_illegal
            && res.addr == 16'h0000;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset state");

    // Result holds between pulses so a slow reader still finds it
    property p_res_hold;
        @(posedge sys_clk) disable iff (reset)
        (!res_valid && !$past(reset)) |-> $stable(res);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result moved");

    property p_one_pulse;
        @(posedge sys_clk) disable iff (reset)
        res_valid |=> !res_valid;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("long pulse");

    // Short, long, illegal, second index and the 1FE ceiling
    c_short: cover property (@(posedge sys_clk) state_q == WAIT_LO);
    c_long: cover property (@(posedge sys_clk) state_q == LO);
    c_illegal: cover property (@(posedge sys_clk) res_valid && res_illegal);
    c_second_index: cover property (@(posedge sys_clk)
        req_valid && req_ready && req.use_second_index);
    c_short_max: cover property (@(posedge sys_clk)
        res_valid && res.addr == 16'h01FE);
endmodule // indirect_indexed_address_gen

/* tb/ptr_mem_model.sv */
/* Pointer memory model: one-cycle read, byte = address low byte ^ A5.
   Assumes reads come as mem_rd with mem_addr. */
module ptr_mem_model (
    // Clock
    input wire logic sys_clk,
    // Read port
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial mem_rdata = 8'h00;
    // Bus inverts outside a read so stale data never passes for good
    always @(posedge sys_clk)
        mem_rdata <= mem_rd ? mem_addr[7:0] ^ 8'hA5 : ~mem_rdata;
endmodule // ptr_mem_model

/* tb/indirect_indexed_address_gen_tb.sv */
/* Self-checking bench for the indirect indexed address generator.
   Assumes one-cycle memory and pulsed results as the design states. */
module indirect_indexed_address_gen_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, req_valid, req_ready, mem_rd;
    logic res_valid, res_illegal;
    logic [7:0] index_first, index_second, mem_rdata, ptr, idx;
    logic [15:0] mem_addr, e;
    iia_pkg::request_t req;
    iia_pkg::result_t res;
    logic [20:0] exp_q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h02E4E3C6;
    indirect_indexed_address_gen dut_u (.sys_clk, .reset, .req_valid,
        .req_ready, .req, .index_first, .index_second, .mem_rd, .mem_addr,
        .mem_rdata, .res_valid, .res, .res_illegal);
    ptr_mem_model mem_u (.sys_clk, .mem_rd, .mem_addr, .mem_rdata);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input string what, input logic [20:0] exp_v,
        input logic [20:0] got);
        total_checks++;
        if (got !== exp_v)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp_v, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
    always @(negedge sys_clk)
        if (res_valid === 1'b1)
            cmp("result", exp_q.pop_front(), {res_illegal, res});
    initial
    begin
        reset = 1;
        req_valid = 0;
        req = '0;
        index_first = 0;
        index_second = 0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 0;
        // First two hit the 1FE short limit and the FFFF long wrap
        for (int i = 0; i < 60; i++)
        begin
            seed = xs(seed);
            req.long_form = (i < 2) ? i[0] : seed[8];
            req.use_second_index = seed[9];
            req.op = iia_pkg::op_t'((i < 11) ? i : seed[15:12] % 11);
            req.ptr_loc = (i < 2) ? 8'h5A : seed[7:0];
            index_first = (i < 2) ? 8'hFF : seed[23:16];
            index_second = (i < 2) ? 8'hFF : seed[31:24];
            req_valid = 1;
            idx = req.use_second_index ? index_second : index_first;
            ptr = req.ptr_loc ^ 8'hA5;
            e = req.long_form ? {ptr, (req.ptr_loc + 8'h01) ^ 8'hA5} + idx
                : ptr + idx;
            exp_q.push_back(req.op == iia_pkg::other_op
                ? {1'b1, 16'h0000, req.op} : {1'b0, e, req.op});
            while (req_ready !== 1'b1)
                @(negedge sys_clk);
            @(negedge sys_clk);
            // Held request while busy must be ignored
            req.ptr_loc = ~req.ptr_loc;
            for (int k = 0; k < 8 && res_valid !== 1'b1; k++)
                @(negedge sys_clk);
        end
        req_valid = 0;
        repeat (4) @(negedge sys_clk);
        cmp("queue", 21'h000000, 21'(exp_q.size()));
        close_out();
    end
endmodule // indirect_indexed_address_gen_tb
